// ==== verif/fhvg_array_model.sv ====
// fhvg_array_model: behavioural flash array on the gate's read bus.
// assumes the gate samples array data combinationally in its read cycle.
`timescale 1ns/1ns
module fhvg_array_model
	import fhvg_pkg::*;
(
	input  wire logic [FHVG_AW-1:0] addr_in,  // byte address
	output logic      [FHVG_DW-1:0] data_out  // array data
);
	// address pattern reads FF only where the low byte is C3, so padding shows up at the tested addresses
	assign data_out = addr_in[7:0] ^ 8'h3C;
endmodule

// ==== verif/testbench.sv ====
// testbench: register port tests of the high-voltage register gate.
// assumes the array model on the read bus and a 125 MHz clock.
`timescale 1ns/1ns
module testbench;
	import fhvg_pkg::*;
	logic               clk_in, rst_b_in, hv, pm, wr, rd, flag;
	logic [FHVG_AW-1:0] addr;
	logic [FHVG_DW-1:0] wdata, ard, rdata, ctl, es1, es2;
	int                 errors, checks_done, cycles;
	fhvg_gate i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .hv_compare_in(hv),
		.prog_mode_in(pm), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.array_rdata_in(ard), .rdata_out(rdata), .flash_control_out(ctl),
		.erase_sel_1_out(es1), .erase_sel_2_out(es2), .hv_flag_out(flag));
	fhvg_array_model i_array (.addr_in(addr), .data_out(ard));
	// system clock, 8 ns period
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// hang guard, far above the cycles the tests need, armed before any control write
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors = errors + 1;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [16:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [16:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// flag must lag the comparator by three edges: the two synchroniser stages and the flag register
	task automatic hvset(input logic v);
		@(posedge clk_in);
		hv <= v;
		repeat (2) @(posedge clk_in);
		#1;
		chk({7'h00, flag}, {7'h00, ~v});
		@(posedge clk_in);
		#1;
		chk({7'h00, flag}, {7'h00, v});
	endtask
	task automatic report_and_stop();
		if (errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		cycles = 0;
		errors = 0;
		checks_done = 0;
		{rst_b_in, hv, pm, wr, rd} = 5'h00; // supply off through power-on reset
		addr = '0;
		wdata = '0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		#1;
		chk(ctl, FHVG_CTL_RST);
		wreg(FHVG_CTL_ADDR, 8'h03);
		wreg(FHVG_EBS1_ADDR, 8'h11);
		rreg(FHVG_CTL_ADDR, FHVG_ALL_ONES);
		rreg(FHVG_EBS1_ADDR, FHVG_ALL_ONES);
		chk(ctl, FHVG_CTL_RST);
		chk(es1, FHVG_EBS_RST);
		hvset(1'b1);
		wreg(FHVG_CTL_ADDR, 8'h05);
		wreg(FHVG_EBS1_ADDR, 8'h5A);
		wreg(FHVG_EBS2_ADDR, 8'hA5);
		rreg(FHVG_EBS2_ADDR, 8'hA5);
		rreg(FHVG_CTL_ADDR, 8'h85);
		rreg(FHVG_EBS1_ADDR, 8'h5A);
		rreg(17'h0FF81, 8'h81 ^ 8'h3C);
		// control program and erase bits cleared before the supply is released; both block selects stay set
		wreg(FHVG_CTL_ADDR, 8'h00);
		rreg(FHVG_CTL_ADDR, FHVG_CTL_RST);
		hvset(1'b0);
		// registers fall back one edge after the flag drops
		@(posedge clk_in);
		#1;
		chk(ctl, FHVG_CTL_RST);
		chk(es1, FHVG_EBS_RST);
		chk(es2, FHVG_EBS_RST);
		rreg(FHVG_CTL_ADDR, FHVG_ALL_ONES);
		@(posedge clk_in);
		pm <= 1'b1;
		rreg(FHVG_ARRAY_TOP, FHVG_ALL_ONES);
		rreg(17'h1FFFF, FHVG_ALL_ONES);
		rreg(17'h07FFF, 8'hFF ^ 8'h3C);
		// reset during operation: hold it ten clocks, then release the supply
		@(posedge clk_in);
		pm <= 1'b0;
		hvset(1'b1);
		wreg(FHVG_CTL_ADDR, 8'h05);
		wreg(FHVG_EBS2_ADDR, 8'h69);
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		hv <= 1'b0;
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		#1;
		chk({7'h00, flag}, 8'h00);
		chk(ctl, FHVG_CTL_RST);
		chk(es2, FHVG_EBS_RST);
		rreg(FHVG_CTL_ADDR, FHVG_ALL_ONES);
		report_and_stop();
	end
endmodule

// ==== verilog/fhvg_gate.sv ====
// fhvg_gate: flash control and erase block select registers, gated by
// the high-voltage detect flag, plus programmer-mode all-ones padding.
// assumes a one-cycle strobe register port and an external array read bus.
//
// Summary of operation
// - high-voltage flag follows the supply comparator threshold decision.
// - with the flag set, control and both block selects accept writes.
// - control at FF80, block selects at FF82 and FF83, only under high voltage.
// - user mode with high voltage: control read/write, reset value 80.
// - user mode without high voltage: control address ignores writes, reads FF.
// - bit 7 at the control address always reads one.
// - programmer mode: addresses past the array up to 1FFFF read FF.
`timescale 1ns/1ns
module fhvg_gate
	import fhvg_pkg::*;
(
	input  wire logic               clk_in,             // 125 MHz system clock
	input  wire logic               rst_b_in,           // synchronous reset, active low
	input  wire logic               hv_compare_in,      // supply pin comparator output
	input  wire logic               prog_mode_in,       // 1: programmer mode
	input  wire logic [FHVG_AW-1:0] addr_in,            // byte address
	input  wire logic [FHVG_DW-1:0] wdata_in,           // write data
	input  wire logic               wr_in,              // write strobe
	input  wire logic               rd_in,              // read strobe
	input  wire logic [FHVG_DW-1:0] array_rdata_in,     // flash array read data
	output logic      [FHVG_DW-1:0] rdata_out,          // read data, cycle after rd_in
	output logic      [FHVG_DW-1:0] flash_control_out,  // control register
	output logic      [FHVG_DW-1:0] erase_sel_1_out,    // erase block select 1
	output logic      [FHVG_DW-1:0] erase_sel_2_out,    // erase block select 2
	output logic                    hv_flag_out         // registered high-voltage flag
);
	typedef struct packed {
		logic               hv;
		logic [FHVG_DW-1:0] ctl;
		logic [FHVG_DW-1:0] ebs1;
		logic [FHVG_DW-1:0] ebs2;
		logic [FHVG_DW-1:0] rdata;
	} fhvg_state_s;

	// registered state; the flag lags the comparator by three edges in all
	fhvg_state_s st_q;
	fhvg_state_s st_d;
	logic        hv_sync;  // comparator after the two synchroniser stages

	// comparator output is asynchronous to the bus; sync it first
	fhvg_sync u_hv_sync (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.level_in  (hv_compare_in),
		.level_out (hv_sync)
	);

	// register gating, write and read decode
	always_comb begin
		st_d       = st_q;
		st_d.hv    = hv_sync;
		// read data stand one cycle only, zero when no read was taken
		st_d.rdata = FHVG_ZERO;
		// gating uses the registered flag so decode and readback agree
		if (!st_q.hv) begin
			// registers drop back so no program/erase bit survives supply loss
			st_d.ctl  = FHVG_CTL_RST;
			st_d.ebs1 = FHVG_EBS_RST;
			st_d.ebs2 = FHVG_EBS_RST;
		end else if (wr_in) begin
			unique case (addr_in)
				FHVG_CTL_ADDR: begin
					st_d.ctl = wdata_in | FHVG_CTL_RST;
				end
				FHVG_EBS1_ADDR: begin
					st_d.ebs1 = wdata_in;
				end
				FHVG_EBS2_ADDR: begin
					st_d.ebs2 = wdata_in;
				end
				default: begin
					// other addresses belong to the array, nothing stored here
					st_d.ctl = st_q.ctl;
				end
			endcase
		end
		if (rd_in) begin
			if (prog_mode_in) begin
				// unimplemented programmer range pads with ones
				st_d.rdata = (addr_in >= FHVG_ARRAY_TOP) ? FHVG_ALL_ONES : array_rdata_in;
			end else if (addr_in == FHVG_CTL_ADDR) begin
				st_d.rdata = st_q.hv ? st_q.ctl : FHVG_ALL_ONES;
			end else if (addr_in == FHVG_EBS1_ADDR) begin
				st_d.rdata = st_q.hv ? st_q.ebs1 : FHVG_ALL_ONES;
			end else if (addr_in == FHVG_EBS2_ADDR) begin
				st_d.rdata = st_q.hv ? st_q.ebs2 : FHVG_ALL_ONES;
			end else begin
				st_d.rdata = array_rdata_in;
			end
		end
	end

	// reset drops the flag, so registers stay closed until the supply is seen again
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			st_q.hv    <= 1'b0;
			st_q.ctl   <= FHVG_CTL_RST;
			st_q.ebs1  <= FHVG_EBS_RST;
			st_q.ebs2  <= FHVG_EBS_RST;
			st_q.rdata <= FHVG_ZERO;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs come straight off the state register
	assign rdata_out         = st_q.rdata;
	assign flash_control_out = st_q.ctl;
	assign erase_sel_1_out   = st_q.ebs1;
	assign erase_sel_2_out   = st_q.ebs2;
	assign hv_flag_out       = st_q.hv;

	// checks on the gate
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence user_rd_s(logic [16:0] a);
		rd_in && !prog_mode_in && addr_in == a;
	endsequence

	sequence hv_wr_s(logic [16:0] a);
		hv_flag_out && wr_in && addr_in == a;
	endsequence

	// write, one cycle without a write, then a user read of the same byte
	sequence wr_then_rd_s(logic [16:0] a);
		hv_wr_s(a) ##1 (hv_flag_out && !wr_in) ##1 (hv_flag_out and user_rd_s(a));
	endsequence

	hv_follow_a: assert property (
		hv_compare_in [*3] |=> hv_flag_out)
		else $error("flag did not follow comparator");
	hv_sync_a: assert property (
		$changed(hv_flag_out) |-> hv_flag_out == $past(hv_compare_in, 3))
		else $error("flag changed without synchronised cause");
	ctl_write_a: assert property (
		hv_wr_s(FHVG_CTL_ADDR) |=> flash_control_out[6:0] == $past(wdata_in[6:0]))
		else $error("control write not taken");
	ebs_map_a: assert property (
		wr_then_rd_s(FHVG_EBS2_ADDR)
		|=> rdata_out == $past(wdata_in, 3))
		else $error("block select 2 readback wrong");
	ctl_reset_a: assert property (disable iff (1'b0)
		!rst_b_in |=> flash_control_out == FHVG_CTL_RST)
		else $error("control reset value wrong");
	reserved_read_a: assert property (
		(!hv_flag_out and user_rd_s(FHVG_CTL_ADDR)) |=> rdata_out == FHVG_ALL_ONES)
		else $error("reserved control read not ones");
	hv_bit_a: assert property (
		user_rd_s(FHVG_CTL_ADDR) |=> rdata_out[FHVG_CTL_HV_BIT])
		else $error("bit 7 read as zero");
	prog_pad_a: assert property (
		rd_in && prog_mode_in && addr_in >= FHVG_ARRAY_TOP |=> rdata_out == FHVG_ALL_ONES)
		else $error("programmer pad not ones");

	// the flag position is hardwired high whatever the register holds
	ctl_bit7_a: assert property (
		flash_control_out[FHVG_CTL_HV_BIT])
		else $error("control bit 7 cleared");

	// block select writes land one cycle after the strobe
	ebs1_write_a: assert property (
		hv_wr_s(FHVG_EBS1_ADDR) |=> erase_sel_1_out == $past(wdata_in))
		else $error("block select 1 write not taken");

	ebs2_write_a: assert property (
		hv_wr_s(FHVG_EBS2_ADDR) |=> erase_sel_2_out == $past(wdata_in))
		else $error("block select 2 write not taken");

	// without the flag nothing may hold a program or erase bit
	drop_clear_a: assert property (
		!hv_flag_out |=> flash_control_out == FHVG_CTL_RST &&
			erase_sel_1_out == FHVG_EBS_RST && erase_sel_2_out == FHVG_EBS_RST)
		else $error("registers not cleared without flag");

	// a control write without the flag changes nothing
	write_ignore_a: assert property (
		!hv_flag_out && wr_in && addr_in == FHVG_CTL_ADDR |=>
			flash_control_out == FHVG_CTL_RST)
		else $error("control write taken without flag");

	// falling side of the flag follows the comparator with the same lag
	flag_fall_a: assert property (
		!hv_compare_in [*3] |=> !hv_flag_out)
		else $error("flag did not drop with comparator");

	// the synchroniser output lags the pin by exactly two edges
	sync_lag_a: assert property (
		$changed(hv_sync) |-> hv_sync == $past(hv_compare_in, 2))
		else $error("synchroniser lag wrong");

	// with the flag set the control address reads the register itself
	ctl_read_a: assert property (
		(hv_flag_out and user_rd_s(FHVG_CTL_ADDR)) |=>
			rdata_out == $past(flash_control_out))
		else $error("control readback differs from register");

	// block select 1 is closed like the control register without the flag
	ebs1_reserved_a: assert property (
		(!hv_flag_out and user_rd_s(FHVG_EBS1_ADDR)) |=> rdata_out == FHVG_ALL_ONES)
		else $error("reserved block select read not ones");

	// below the array top programmer reads pass the array data through
	prog_array_a: assert property (
		rd_in && prog_mode_in && addr_in < FHVG_ARRAY_TOP |=>
			rdata_out == $past(array_rdata_in))
		else $error("programmer array read wrong");

	// control write then readback keeps bits 6:0 and forces bit 7
	ctl_map_a: assert property (
		wr_then_rd_s(FHVG_CTL_ADDR) |=> rdata_out == ($past(wdata_in, 3) | FHVG_CTL_RST))
		else $error("control readback after write wrong");
endmodule

// ==== verilog/fhvg_pkg.sv ====
// fhvg_pkg: constants for the flash high-voltage register gate.
// assumes a byte-wide register port with a 17-bit byte address.
package fhvg_pkg;
	localparam int          FHVG_AW          = 17;
	localparam int          FHVG_DW          = 8;
	// register byte addresses
	localparam logic [16:0] FHVG_CTL_ADDR    = 17'h0FF80;
	localparam logic [16:0] FHVG_EBS1_ADDR   = 17'h0FF82;
	localparam logic [16:0] FHVG_EBS2_ADDR   = 17'h0FF83;
	// first programmer address past the implemented array (largest variant)
	localparam logic [16:0] FHVG_ARRAY_TOP   = 17'h08000;
	// field positions
	localparam int          FHVG_CTL_HV_BIT  = 7;
	// reset and fill values
	localparam logic [7:0]  FHVG_CTL_RST     = 8'h80;
	localparam logic [7:0]  FHVG_EBS_RST     = 8'h00;
	localparam logic [7:0]  FHVG_ALL_ONES    = 8'hFF;
	localparam logic [7:0]  FHVG_ZERO        = 8'h00;
	// synchroniser depth for the comparator output
	localparam int          FHVG_SYNC_STAGES = 2;
endpackage

// ==== verilog/fhvg_sync.sv ====
// fhvg_sync: two-flop synchroniser for a level input.
// assumes the input may change at any time relative to clk_in.
`timescale 1ns/1ns
module fhvg_sync
	import fhvg_pkg::*;
(
	input  wire logic clk_in,    // system clock
	input  wire logic rst_b_in,  // synchronous reset, active low
	input  wire logic level_in,  // asynchronous level
	output logic      level_out  // synchronised level
);
	typedef struct packed {
		logic [FHVG_SYNC_STAGES-1:0] stage;
	} fhvg_sync_s;

	fhvg_sync_s st_q;
	fhvg_sync_s st_d;

	// shift chain; only the last stage is read outside
	always_comb begin
		st_d.stage = {st_q.stage[FHVG_SYNC_STAGES-2:0], level_in};
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level_out = st_q.stage[FHVG_SYNC_STAGES-1];
endmodule
